// ==== rtl/gd_regs.sv ====
// fault status and gate drive strength registers behind the serial link
// assumes: fault levels may be asynchronous, sleep request is on clk_in;
// chip select idles at least 500 ns between frames and falls well
// before the first link clock edge
//
// Overview of operation
// - supply faults bits 10..8, default zero
// - supply faults bits 6..4, default zero
// - supply faults bits 2..0, default zero
// - gate faults bits 10..5, rest reserved
// - drive registers readable and writable by host
// - reads and writes to fault registers keep drive registers
// - drive registers load defaults at reset
// - drive registers reload defaults on sleep entry
// - high side peak time bits 9:8
// - high side sink current bits 7:4
// - high side source current bits 3:0
// - low side peak time bits 9:8
// - low side sink current bits 7:4
// - low side source current bits 3:0
// - frame: read flag, address, eleven data bits
// - response carries addressed register, low eleven bits
`timescale 1ns/1ps
`default_nettype none
`include "gd_map.svh"
module gd_regs
  import gd_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic spi_sclk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_sdi_in,
  output logic spi_sdo_out,
  output logic spi_sdo_oe_n_out,
  input wire logic power_supply_undervoltage_level2_fault_in,
  input wire logic watchdog_expiry_fault_in,
  input wire logic overtemperature_shutdown_fault_in,
  input wire logic regulator_output_undervoltage_fault_in,
  input wire logic analog_supply_undervoltage_fault_in,
  input wire logic low_side_gate_supply_fault_in,
  input wire logic charge_pump_undervoltage_level2_fault_in,
  input wire logic charge_pump_overvoltage_fault_in,
  input wire logic charge_pump_absolute_overvoltage_fault_in,
  input wire logic gate_fault_high_phase_a_in,
  input wire logic gate_fault_low_phase_a_in,
  input wire logic gate_fault_high_phase_b_in,
  input wire logic gate_fault_low_phase_b_in,
  input wire logic gate_fault_high_phase_c_in,
  input wire logic gate_fault_low_phase_c_in,
  input wire logic sleep_request_in,
  output logic [1:0] high_side_peak_time_out,
  output logic [3:0] high_side_sink_current_out,
  output logic [3:0] high_side_source_current_out,
  output logic [1:0] low_side_peak_time_out,
  output logic [3:0] low_side_sink_current_out,
  output logic [3:0] low_side_source_current_out,
  output logic [10:0] high_side_peak_time_ns_out,
  output logic [10:0] high_side_sink_ma_out,
  output logic [10:0] high_side_source_ma_out,
  output logic [10:0] low_side_peak_time_ns_out,
  output logic [10:0] low_side_sink_ma_out,
  output logic [10:0] low_side_source_ma_out
);

  // peak time code to nanoseconds
  function automatic logic [10:0] peak_time_ns(input logic [1:0] code);
    case (code)
      2'h0: peak_time_ns = `GD_T0_NS;
      2'h1: peak_time_ns = `GD_T1_NS;
      2'h2: peak_time_ns = `GD_T2_NS;
      default: peak_time_ns = `GD_T3_NS;
    endcase
  endfunction : peak_time_ns

  // sink current code to milliamps, unused codes fall back
  function automatic logic [10:0] sink_ma(input logic [3:0] code);
    case (code)
      4'h0: sink_ma = 11'h014;
      4'h1: sink_ma = 11'h01E;
      4'h2: sink_ma = 11'h028;
      4'h3: sink_ma = 11'h032;
      4'h4: sink_ma = 11'h03C;
      4'h5: sink_ma = 11'h046;
      4'h6: sink_ma = 11'h050;
      4'h7: sink_ma = 11'h0FA;
      4'h8: sink_ma = 11'h1F4;
      4'h9: sink_ma = 11'h2EE;
      4'hA: sink_ma = 11'h3E8;
      4'hB: sink_ma = 11'h4E2;
      default: sink_ma = `GD_SINK_FALLBACK_MA;
    endcase
  endfunction : sink_ma

  // source current code to milliamps, unused codes fall back
  function automatic logic [10:0] source_ma(input logic [3:0] code);
    case (code)
      4'h0: source_ma = 11'h00A;
      4'h1: source_ma = 11'h014;
      4'h2: source_ma = 11'h01E;
      4'h3: source_ma = 11'h028;
      4'h4: source_ma = 11'h032;
      4'h5: source_ma = 11'h03C;
      4'h6: source_ma = 11'h046;
      4'h7: source_ma = 11'h07D;
      4'h8: source_ma = 11'h0FA;
      4'h9: source_ma = 11'h1F4;
      4'hA: source_ma = 11'h2EE;
      4'hB: source_ma = 11'h3E8;
      default: source_ma = `GD_SRC_FALLBACK_MA;
    endcase
  endfunction : source_ma

  // write frame aimed at one drive register
  function automatic logic wr_hit(input gd_frame_t frame,
    input gd_addr_t addr);
    wr_hit = ~frame[`GD_RW_BIT] &
      (frame[`GD_ADDR_MSB:`GD_ADDR_LSB] == addr);
  endfunction : wr_hit

  // drive register readback, reserved top bit reads zero
  function automatic gd_word_t drive_word(input logic [1:0] t,
    input logic [3:0] snk, input logic [3:0] src);
    drive_word = {1'b0, t, snk, src};
  endfunction : drive_word

  gd_addr_t link_addr;
  gd_frame_t link_frame;
  gd_count_t link_bits;
  gd_word_t rd_data;
  gd_word_t sup_live;
  gd_word_t gate_live;
  gd_word_t sup_snap_r;
  gd_word_t gate_snap_r;
  gd_word_t sup_meta_r;
  gd_word_t sup_sync_r;
  gd_word_t gate_meta_r;
  gd_word_t gate_sync_r;
  logic cs_meta_r;
  logic cs_sync_r;
  logic cs_prev_r;
  logic frame_end;
  logic commit;
  logic wr_hs;
  logic wr_ls;
  logic sleep_prev_r;
  logic sleep_entry;
  logic [1:0] hs_time_r;
  logic [3:0] hs_sink_r;
  logic [3:0] hs_src_r;
  logic [1:0] ls_time_r;
  logic [3:0] ls_sink_r;
  logic [3:0] ls_src_r;
  logic [10:0] hs_time_ns_r;
  logic [10:0] hs_sink_ma_r;
  logic [10:0] hs_src_ma_r;
  logic [10:0] ls_time_ns_r;
  logic [10:0] ls_sink_ma_r;
  logic [10:0] ls_src_ma_r;

  gd_spi_link u_link (
    .sclk_in(spi_sclk_in),
    .ncs_n_in(spi_cs_n_in),
    .sdi_in(spi_sdi_in),
    .rd_data_in(rd_data),
    .addr_out(link_addr),
    .frame_out(link_frame),
    .bits_out(link_bits),
    .sdo_out(spi_sdo_out)
  );

  // pin released while deselected
  assign spi_sdo_oe_n_out = spi_cs_n_in;

  // chip select into the system clock
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cs_meta_r <= 1'b1;
      cs_sync_r <= 1'b1;
    end else begin
      cs_meta_r <= spi_cs_n_in;
      cs_sync_r <= cs_meta_r;
    end
  end

  // last synced level, for the deselect edge
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cs_prev_r <= 1'b1;
    end else begin
      cs_prev_r <= cs_sync_r;
    end
  end

  assign frame_end = cs_sync_r & ~cs_prev_r;

  // only whole sixteen bit frames act; link words are still after deselect
  assign commit = frame_end & (link_bits == `GD_FRAME_BITS);
  assign wr_hs = commit &
    wr_hit(link_frame, `GD_ADDR_HS);
  assign wr_ls = commit &
    wr_hit(link_frame, `GD_ADDR_LS);

  // sleep entry is the rising edge of the request
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sleep_prev_r <= 1'b0;
    end else begin
      sleep_prev_r <= sleep_request_in;
    end
  end

  assign sleep_entry = sleep_request_in & ~sleep_prev_r;

  // live fault vectors, reserved positions tied low
  always_comb begin
    sup_live = `GD_FAULT_RST;
    sup_live[`GD_SUP_PSU_UV2] =
      power_supply_undervoltage_level2_fault_in;
    sup_live[`GD_SUP_WDOG] = watchdog_expiry_fault_in;
    sup_live[`GD_SUP_OVERTEMPERATURE_SHUTDOWN_FAULT] = overtemperature_shutdown_fault_in;
    sup_live[`GD_SUP_REG_UV] = regulator_output_undervoltage_fault_in;
    sup_live[`GD_SUP_ANA_UV] = analog_supply_undervoltage_fault_in;
    sup_live[`GD_SUP_LSGS] = low_side_gate_supply_fault_in;
    sup_live[`GD_SUP_CP_UV2] = charge_pump_undervoltage_level2_fault_in;
    sup_live[`GD_SUP_CP_OV] = charge_pump_overvoltage_fault_in;
    sup_live[`GD_SUP_CP_OVABS] =
      charge_pump_absolute_overvoltage_fault_in;
  end

  always_comb begin
    gate_live = `GD_FAULT_RST;
    gate_live[`GD_GATE_HA] = gate_fault_high_phase_a_in;
    gate_live[`GD_GATE_LA] = gate_fault_low_phase_a_in;
    gate_live[`GD_GATE_HB] = gate_fault_high_phase_b_in;
    gate_live[`GD_GATE_LB] = gate_fault_low_phase_b_in;
    gate_live[`GD_GATE_HC] = gate_fault_high_phase_c_in;
    gate_live[`GD_GATE_LC] = gate_fault_low_phase_c_in;
  end

  // fault levels come from analog monitors, two flops before use
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sup_meta_r <= `GD_FAULT_RST;
      sup_sync_r <= `GD_FAULT_RST;
      gate_meta_r <= `GD_FAULT_RST;
      gate_sync_r <= `GD_FAULT_RST;
    end else begin
      sup_meta_r <= sup_live;
      sup_sync_r <= sup_meta_r;
      gate_meta_r <= gate_live;
      gate_sync_r <= gate_meta_r;
    end
  end

  // status snapshots follow the faults only while the link is idle,
  // so the link clock never sees them move mid-frame
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sup_snap_r <= `GD_FAULT_RST;
      gate_snap_r <= `GD_FAULT_RST;
    end else if (cs_sync_r) begin
      sup_snap_r <= sup_sync_r;
      gate_snap_r <= gate_sync_r;
    end
  end

  // high side drive: only reset, a write frame or sleep entry changes it
  always_ff @(posedge clk_in) begin
    if (srst_in || sleep_entry) begin
      hs_time_r <= `GD_TIME_RST;
      hs_sink_r <= `GD_SINK_RST;
      hs_src_r <= `GD_SRC_RST;
    end else if (wr_hs) begin
      hs_time_r <= link_frame[`GD_TIME_MSB:`GD_TIME_LSB];
      hs_sink_r <= link_frame[`GD_SINK_MSB:`GD_SINK_LSB];
      hs_src_r <= link_frame[`GD_SRC_MSB:`GD_SRC_LSB];
    end
  end

  // low side drive: only reset, a write frame or sleep entry changes it
  always_ff @(posedge clk_in) begin
    if (srst_in || sleep_entry) begin
      ls_time_r <= `GD_TIME_RST;
      ls_sink_r <= `GD_SINK_RST;
      ls_src_r <= `GD_SRC_RST;
    end else if (wr_ls) begin
      ls_time_r <= link_frame[`GD_TIME_MSB:`GD_TIME_LSB];
      ls_sink_r <= link_frame[`GD_SINK_MSB:`GD_SINK_LSB];
      ls_src_r <= link_frame[`GD_SRC_MSB:`GD_SRC_LSB];
    end
  end

  // response word for the address the link has seen
  always_comb begin
    case (link_addr)
      `GD_ADDR_SUPPLY: rd_data = sup_snap_r;
      `GD_ADDR_GATE: rd_data = gate_snap_r;
      `GD_ADDR_HS: rd_data = drive_word(hs_time_r, hs_sink_r, hs_src_r);
      `GD_ADDR_LS: rd_data = drive_word(ls_time_r, ls_sink_r, ls_src_r);
      default: rd_data = `GD_FAULT_RST;
    endcase
  end

  // decoded drive figures
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      hs_time_ns_r <= peak_time_ns(`GD_TIME_RST);
      hs_sink_ma_r <= sink_ma(`GD_SINK_RST);
      hs_src_ma_r <= source_ma(`GD_SRC_RST);
    end else begin
      hs_time_ns_r <= peak_time_ns(hs_time_r);
      hs_sink_ma_r <= sink_ma(hs_sink_r);
      hs_src_ma_r <= source_ma(hs_src_r);
    end
  end

  // low side decoded figures
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ls_time_ns_r <= peak_time_ns(`GD_TIME_RST);
      ls_sink_ma_r <= sink_ma(`GD_SINK_RST);
      ls_src_ma_r <= source_ma(`GD_SRC_RST);
    end else begin
      ls_time_ns_r <= peak_time_ns(ls_time_r);
      ls_sink_ma_r <= sink_ma(ls_sink_r);
      ls_src_ma_r <= source_ma(ls_src_r);
    end
  end

  assign high_side_peak_time_out = hs_time_r;
  assign high_side_sink_current_out = hs_sink_r;
  assign high_side_source_current_out = hs_src_r;
  assign low_side_peak_time_out = ls_time_r;
  assign low_side_sink_current_out = ls_sink_r;
  assign low_side_source_current_out = ls_src_r;
  assign high_side_peak_time_ns_out = hs_time_ns_r;
  assign high_side_sink_ma_out = hs_sink_ma_r;
  assign high_side_source_ma_out = hs_src_ma_r;
  assign low_side_peak_time_ns_out = ls_time_ns_r;
  assign low_side_sink_ma_out = ls_sink_ma_r;
  assign low_side_source_ma_out = ls_src_ma_r;
endmodule : gd_regs
`default_nettype wire

// ==== rtl/gd_map.svh ====
// register map, field positions, reset values and decode figures
// assumes: included by bare name wherever the map is needed
`ifndef GD_MAP_SVH
`define GD_MAP_SVH

// register offsets on the serial link
`define GD_ADDR_SUPPLY 4'h3
`define GD_ADDR_GATE 4'h4
`define GD_ADDR_HS 4'h5
`define GD_ADDR_LS 4'h6

// frame layout
`define GD_FRAME_BITS 5'h10
`define GD_BITS_SAT 5'h11
`define GD_ADDR_DONE 5'h05
`define GD_RW_BIT 15
`define GD_ADDR_MSB 14
`define GD_ADDR_LSB 11
`define GD_DATA_MSB 10

// supply fault status bits
`define GD_SUP_PSU_UV2 10
`define GD_SUP_WDOG 9
`define GD_SUP_OVERTEMPERATURE_SHUTDOWN_FAULT 8
`define GD_SUP_REG_UV 6
`define GD_SUP_ANA_UV 5
`define GD_SUP_LSGS 4
`define GD_SUP_CP_UV2 2
`define GD_SUP_CP_OV 1
`define GD_SUP_CP_OVABS 0

// gate-source fault bits
`define GD_GATE_HA 10
`define GD_GATE_LA 9
`define GD_GATE_HB 8
`define GD_GATE_LB 7
`define GD_GATE_HC 6
`define GD_GATE_LC 5

// drive strength fields
`define GD_TIME_MSB 9
`define GD_TIME_LSB 8
`define GD_SINK_MSB 7
`define GD_SINK_LSB 4
`define GD_SRC_MSB 3
`define GD_SRC_LSB 0

// reset values
`define GD_FAULT_RST 11'h000
`define GD_TIME_RST 2'h3
`define GD_SINK_RST 4'h4
`define GD_SRC_RST 4'h4

// decoded figures: time in ns, current in mA
`define GD_T0_NS 11'h0DC
`define GD_T1_NS 11'h1B8
`define GD_T2_NS 11'h370
`define GD_T3_NS 11'h6F4
`define GD_SINK_FALLBACK_MA 11'h03C
`define GD_SRC_FALLBACK_MA 11'h032

`endif

// ==== rtl/gd_pkg.sv ====
// shared types of the gate driver register bank
// assumes: nothing beyond the map header
package gd_pkg;
  typedef logic [3:0] gd_addr_t;
  typedef logic [10:0] gd_word_t;
  typedef logic [15:0] gd_frame_t;
  typedef logic [4:0] gd_count_t;
endpackage : gd_pkg

// ==== rtl/gd_spi_link.sv ====
// serial link front end, runs on the link clock
// assumes: mode with sampling on rising edge, shifting on falling edge;
// chip select high between frames resets the frame state
`timescale 1ns/1ps
`default_nettype none
`include "gd_map.svh"
module gd_spi_link
  import gd_pkg::*;
(
  input wire logic sclk_in,
  input wire logic ncs_n_in,
  input wire logic sdi_in,
  input wire gd_word_t rd_data_in,
  output gd_addr_t addr_out,
  output gd_frame_t frame_out,
  output gd_count_t bits_out,
  output logic sdo_out
);
  logic fresh_r;
  gd_count_t cnt_r;
  gd_count_t cnt_nxt;
  gd_frame_t rx_r;
  gd_addr_t addr_r;
  logic sdo_r;
  logic [3:0] idx;

  // marks the first edge of a frame
  always_ff @(posedge sclk_in or posedge ncs_n_in) begin
    if (ncs_n_in) begin
      fresh_r <= 1'b1;
    end else begin
      fresh_r <= 1'b0;
    end
  end

  // saturating bit count; anything but sixteen is a frame error
  always_comb begin
    if (fresh_r) begin
      cnt_nxt = 5'h01;
    end else if (cnt_r == `GD_BITS_SAT) begin
      cnt_nxt = cnt_r;
    end else begin
      cnt_nxt = cnt_r + 5'h01;
    end
  end

  always_ff @(posedge sclk_in) begin
    cnt_r <= cnt_nxt;
  end

  // command shift, most significant bit first
  always_ff @(posedge sclk_in) begin
    rx_r <= {rx_r[14:0], sdi_in};
  end

  // address held from fifth bit on
  always_ff @(posedge sclk_in) begin
    if (cnt_nxt == `GD_ADDR_DONE) begin
      addr_r <= {rx_r[2:0], sdi_in};
    end
  end

  assign idx = 4'(5'h0F - cnt_r);

  // top five response bits are zero, then the register contents
  always_ff @(negedge sclk_in or posedge ncs_n_in) begin
    if (ncs_n_in) begin
      sdo_r <= 1'b0;
    end else if (cnt_r >= `GD_ADDR_DONE && cnt_r < `GD_FRAME_BITS) begin
      sdo_r <= rd_data_in[idx];
    end else begin
      sdo_r <= 1'b0;
    end
  end

  assign addr_out = addr_r;
  assign frame_out = rx_r;
  assign bits_out = cnt_r;
  assign sdo_out = sdo_r;
endmodule : gd_spi_link
`default_nettype wire

// ==== test/gd_regs_properties.sv ====
// port checker for the gate driver register bank
// assumes: bound to gd_regs, one clk_in domain
`timescale 1ns/1ps
`default_nettype none
module gd_regs_properties (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_sdo_out,
  input wire logic sleep_request_in,
  input wire logic [1:0] high_side_peak_time_out,
  input wire logic [3:0] high_side_sink_current_out,
  input wire logic [3:0] high_side_source_current_out,
  input wire logic [1:0] low_side_peak_time_out,
  input wire logic [3:0] low_side_sink_current_out,
  input wire logic [3:0] low_side_source_current_out,
  input wire logic [10:0] high_side_peak_time_ns_out,
  input wire logic [10:0] high_side_source_ma_out,
  input wire logic [10:0] low_side_sink_ma_out,
  input wire logic [10:0] high_side_sink_ma_out,
  input wire logic [10:0] low_side_peak_time_ns_out,
  input wire logic [10:0] low_side_source_ma_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  logic [9:0] hs;
  logic [9:0] ls;
  assign hs = {high_side_peak_time_out, high_side_sink_current_out,
    high_side_source_current_out};
  assign ls = {low_side_peak_time_out, low_side_sink_current_out,
    low_side_source_current_out};
  function automatic logic [10:0] t_ns(input logic [1:0] c);
    return c == 2'h0 ? 11'h0DC : c == 2'h1 ? 11'h1B8 :
      c == 2'h2 ? 11'h370 : 11'h6F4;
  endfunction : t_ns
  // s high: sink table, else source table
  function automatic logic [10:0] ma(input logic [3:0] c, input logic s);
    if (c < 4'h7) begin
      return {7'h00, c} * 11'h00A + (s ? 11'h014 : 11'h00A);
    end
    case (c)
      4'h7: return s ? 11'h0FA : 11'h07D;
      4'h8: return s ? 11'h1F4 : 11'h0FA;
      4'h9: return s ? 11'h2EE : 11'h1F4;
      4'hA: return s ? 11'h3E8 : 11'h2EE;
      4'hB: return s ? 11'h4E2 : 11'h3E8;
      default: return s ? 11'h03C : 11'h032;
    endcase
  endfunction : ma
  sequence s_quiet;
    (spi_cs_n_in && $stable(sleep_request_in)) [*8];
  endsequence
  a_hs_reset_dflt: assert property (disable iff (1'b0)
    srst_in |=> hs == 10'h344) else $error("high side not at default");
  a_ls_reset_dflt: assert property (disable iff (1'b0)
    srst_in |=> ls == 10'h344) else $error("low side not at default");
  a_sleep_dflt: assert property ($rose(sleep_request_in) |->
    ##[1:2] (hs == 10'h344 && ls == 10'h344))
    else $error("sleep entry kept drive settings");
  a_idle_hold: assert property (s_quiet |->
    $stable(hs) && $stable(ls)) else $error("drive settings moved idle");
  a_sdo_idle_low: assert property (spi_cs_n_in [*2] |->
    spi_sdo_out == 1'b0) else $error("sdo active while deselected");
  a_hs_time_ns: assert property (1'b1 |-> high_side_peak_time_ns_out ==
    t_ns($past(high_side_peak_time_out))) else $error("time decode wrong");
  a_hs_src_ma: assert property (1'b1 |-> high_side_source_ma_out ==
    ma($past(high_side_source_current_out), 1'b0))
    else $error("source decode wrong");
  a_ls_sink_ma: assert property (1'b1 |-> low_side_sink_ma_out ==
    ma($past(low_side_sink_current_out), 1'b1))
    else $error("sink decode wrong");
  a_hs_sink_ma: assert property (1'b1 |-> high_side_sink_ma_out ==
    ma($past(high_side_sink_current_out), 1'b1))
    else $error("high side sink decode wrong");
  a_ls_time_ns: assert property (1'b1 |-> low_side_peak_time_ns_out ==
    t_ns($past(low_side_peak_time_out))) else $error("low time decode wrong");
  a_ls_src_ma: assert property (1'b1 |-> low_side_source_ma_out ==
    ma($past(low_side_source_current_out), 1'b0))
    else $error("low side source decode wrong");
endmodule : gd_regs_properties
bind gd_regs gd_regs_properties gd_regs_properties_i (.clk_in, .srst_in,
  .spi_cs_n_in, .spi_sdo_out, .sleep_request_in, .high_side_peak_time_out,
  .high_side_sink_current_out, .high_side_source_current_out,
  .low_side_peak_time_out, .low_side_sink_current_out,
  .low_side_source_current_out, .high_side_peak_time_ns_out,
  .high_side_source_ma_out, .low_side_sink_ma_out,
  .high_side_sink_ma_out, .low_side_peak_time_ns_out,
  .low_side_source_ma_out);
`default_nettype wire

// ==== test/gd_host_model.sv ====
// serial host model: 6 ns link clock, still between frames
// assumes: device samples on rising edge and shifts on falling edge
`timescale 1ns/1ps
`default_nettype none
module gd_host_model (
  output logic sclk_out,
  output logic cs_n_out,
  output logic sdi_out,
  input wire logic sdo_in
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  // n other than 16 gives a frame the device must drop
  task automatic xfer(input logic [15:0] f, input int n, input int lead,
    output logic [15:0] r);
    r = 16'h0000;
    cs_n_out = 1'b0;
    #lead;
    for (int i = 0; i < n; i++) begin
      sdi_out = f[15 - i];
      #3 sclk_out = 1'b1;
      r = {r[14:0], sdo_in};
      #3 sclk_out = 1'b0;
    end
    #10 cs_n_out = 1'b1;
    sdi_out = ~sdi_out;
    #600;
  endtask : xfer
endmodule : gd_host_model
`default_nettype wire

// ==== test/tb_top.sv ====
// self-checking bench for the gate driver register bank
// assumes: gd_regs as device, gd_host_model on the serial link
`timescale 1ns/1ps
`default_nettype none
`include "gd_map.svh"
module tb_top;
  import gd_pkg::*;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic sleep_request_in = 1'b0;
  logic [10:0] sup = 11'h000;
  logic [10:0] gat = 11'h000;
  wire logic sclk, cs_n, sdi, sdo, sdo_oe_n, sdo_w;
  wire logic [9:0] hs_pins, ls_pins;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [15:0] r;
  gd_word_t hv, lv, nv;
  gd_word_t pat [3] = '{11'h7FF, 11'h555, 11'h2AA};
  initial forever #2.5 clk_in = ~clk_in;
  // released line toggles so a stale level never reads as data
  assign sdo_w = sdo_oe_n ? clk_in : sdo;
  gd_host_model gd_host_model_i (.sclk_out(sclk), .cs_n_out(cs_n),
    .sdi_out(sdi), .sdo_in(sdo_w));
  gd_regs gd_regs_i (.clk_in, .srst_in, .spi_sclk_in(sclk),
    .spi_cs_n_in(cs_n), .spi_sdi_in(sdi), .spi_sdo_out(sdo),
    .spi_sdo_oe_n_out(sdo_oe_n),
    .power_supply_undervoltage_level2_fault_in(sup[10]),
    .watchdog_expiry_fault_in(sup[9]),
    .overtemperature_shutdown_fault_in(sup[8]),
    .regulator_output_undervoltage_fault_in(sup[6]),
    .analog_supply_undervoltage_fault_in(sup[5]),
    .low_side_gate_supply_fault_in(sup[4]),
    .charge_pump_undervoltage_level2_fault_in(sup[2]),
    .charge_pump_overvoltage_fault_in(sup[1]),
    .charge_pump_absolute_overvoltage_fault_in(sup[0]),
    .gate_fault_high_phase_a_in(gat[10]), .gate_fault_low_phase_a_in(gat[9]),
    .gate_fault_high_phase_b_in(gat[8]), .gate_fault_low_phase_b_in(gat[7]),
    .gate_fault_high_phase_c_in(gat[6]), .gate_fault_low_phase_c_in(gat[5]),
    .sleep_request_in, .high_side_peak_time_out(hs_pins[9:8]),
    .high_side_sink_current_out(hs_pins[7:4]),
    .high_side_source_current_out(hs_pins[3:0]),
    .low_side_peak_time_out(ls_pins[9:8]),
    .low_side_sink_current_out(ls_pins[7:4]),
    .low_side_source_current_out(ls_pins[3:0]),
    .high_side_peak_time_ns_out(),
    .high_side_sink_ma_out(), .high_side_source_ma_out(),
    .low_side_peak_time_ns_out(), .low_side_sink_ma_out(),
    .low_side_source_ma_out());
  function automatic gd_frame_t fr(input logic w, input gd_addr_t a,
    input gd_word_t d);
    return {w, a, d};
  endfunction : fr
  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic acc(input gd_frame_t f, input gd_word_t e, input string nm);
    gd_host_model_i.xfer(f, 16, 25, r);
    chk(nm, {5'h00, e}, r);
  endtask : acc
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end
  initial begin
    repeat (16) @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    acc(fr(1'b1, `GD_ADDR_HS, 11'h000), 11'h344, "hs");
    acc(fr(1'b1, `GD_ADDR_LS, 11'h000), 11'h344, "ls");
    acc(fr(1'b1, `GD_ADDR_SUPPLY, 11'h7FF), 11'h000, "sup");
    acc(fr(1'b1, `GD_ADDR_GATE, 11'h000), 11'h000, "gate");
    $display("test defaults done");
    acc(fr(1'b0, `GD_ADDR_HS, 11'h7FF), 11'h344, "hs old");
    acc(fr(1'b1, `GD_ADDR_HS, 11'h000), 11'h3FF, "hs rsvd");
    acc(fr(1'b1, `GD_ADDR_HS, 11'h000), 11'h3FF, "hs again");
    acc(fr(1'b0, `GD_ADDR_SUPPLY, 11'h7FF), 11'h000, "sup wr");
    acc(fr(1'b0, `GD_ADDR_GATE, 11'h7FF), 11'h000, "gate wr");
    acc(fr(1'b1, `GD_ADDR_GATE, 11'h000), 11'h000, "gate ro");
    acc(fr(1'b0, 4'hF, 11'h7FF), 11'h000, "unmapped wr");
    acc(fr(1'b1, 4'hF, 11'h000), 11'h000, "unmapped");
    $display("test access done");
    foreach (pat[i]) begin
      @(posedge clk_in);
      sup <= pat[i];
      gat <= pat[i];
      repeat (4) @(posedge clk_in);
      nv = pat[i] & 11'h777;
      acc(fr(1'b1, `GD_ADDR_SUPPLY, '0), nv, "sup");
      nv = pat[i] & 11'h7E0;
      acc(fr(1'b1, `GD_ADDR_GATE, '0), nv, "gate");
    end
    acc(fr(1'b1, `GD_ADDR_HS, 11'h000), 11'h3FF, "hs faults");
    $display("test faults done");
    gd_host_model_i.xfer(fr(1'b0, `GD_ADDR_HS, 11'h000), 12, 200, r);
    acc(fr(1'b1, `GD_ADDR_HS, 11'h000), 11'h3FF, "short");
    $display("test short frame done");
    hv = 11'h3FF;
    lv = 11'h344;
    for (int k = 0; k < 16; k++) begin
      nv = {1'b0, k[1:0], k[3:0], k[3:0]};
      acc(fr(1'b0, `GD_ADDR_HS, nv), hv, "hs code");
      hv = nv;
      chk("hs pins", {5'h00, hv}, {6'h00, hs_pins});
      nv = {1'b1, k[1:0], ~k[3:0], k[3:0]};
      acc(fr(1'b0, `GD_ADDR_LS, nv), lv, "ls code");
      lv = {1'b0, nv[9:0]};
      chk("ls pins", {5'h00, lv}, {6'h00, ls_pins});
    end
    acc(fr(1'b1, `GD_ADDR_LS, 11'h000), lv, "ls last");
    $display("test codes done");
    @(posedge clk_in);
    sleep_request_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    acc(fr(1'b1, `GD_ADDR_HS, 11'h000), 11'h344, "hs sleep");
    acc(fr(1'b1, `GD_ADDR_LS, 11'h000), 11'h344, "ls sleep");
    @(posedge clk_in);
    sleep_request_in <= 1'b0;
    acc(fr(1'b0, `GD_ADDR_LS, 11'h0AB), 11'h344, "ls wake");
    acc(fr(1'b1, `GD_ADDR_LS, 11'h000), 11'h0AB, "ls woke");
    @(posedge clk_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    acc(fr(1'b1, `GD_ADDR_LS, 11'h000), 11'h344, "ls reset");
    $display("test sleep and reset done");
    results();
  end
endmodule : tb_top
`default_nettype wire
